// ---- src/alu_jump_unit.sv ----
`timescale 1ns/1ps
// Functional notes
// RL1 - Add, add-with-carry: one cycle, ZCNVH
// RL2 - Word add/sub immediate: two cycles, ZCNVS
// RL3 - Subtract register or constant: one cycle
// RL4 - Borrow forms also subtract carry flag
// RL5 - AND/OR/XOR forms update Z N V only
// RL6 - Ones and twos inversion, one cycle
// RL7 - Bit set ORs mask, clear ANDs inverse
// RL8 - Increment, decrement keep carry untouched
// RL9 - Probe ANDs register with itself
// RL10 - Wipe gives zero; fill loads ones, no flags
// RL11 - Products into fixed pair, two cycles
// RL12 - Fractional products shifted left one bit
// RL13 - Relative two cycles, absolute three cycles
// RL14 - Pointer gotos load Z, extended prefix
// RL15 - Calls four cycles, direct call five
// RL16 - Unlisted flags kept; return saved first
module alu_jump_unit (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic                   op_valid,
	input  wire alu_jump_pkg::op_type   op_code,
	input  wire logic [7:0]             dst_val,
	input  wire logic [7:0]             src_val,
	input  wire logic [7:0]             imm_val,
	input  wire logic [15:0]            word_val,
	input  wire logic [7:0]             flags_in,
	input  wire logic [21:0]            pc_val,
	input  wire logic [11:0]            jump_offset,
	input  wire logic [21:0]            jump_target,
	input  wire logic [15:0]            z_pointer,
	input  wire logic [7:0]             jump_extension_byte,
	output logic                        busy,
	output logic                        done,
	output logic                        res_we,
	output logic [7:0]                  res_data,
	output logic                        word_we,
	output logic [15:0]                 word_data,
	output logic                        prod_we,
	output logic [15:0]                 prod_data,
	output logic                        flags_we,
	output logic [7:0]                  flags_out,
	output logic                        pc_we,
	output logic [21:0]                 pc_data,
	output logic                        ret_we,
	output logic [21:0]                 ret_data
);

	// ------------------------------------------------------------
	// Operand preparation
	// ------------------------------------------------------------
	alu_jump_pkg::op_type op;
	logic        accept;
	logic [7:0]  b;
	logic        cin;
	logic [8:0]  sum9;
	logic [8:0]  dif9;
	logic [8:0]  neg9;
	logic [16:0] wsum;
	logic [16:0] wdif;
	logic [21:0] rel_pc;
	logic [21:0] far_z;
	mult_if      mi ();

	assign op     = op_code;
	assign accept = op_valid & ~busy;
	assign b      = (op == alu_jump_pkg::op_constant_difference ||
		op == alu_jump_pkg::op_borrow_constant_difference) ? imm_val : src_val;
	assign cin    = (op == alu_jump_pkg::op_add_carry || op == alu_jump_pkg::op_borrow_difference
		|| op == alu_jump_pkg::op_borrow_constant_difference) & flags_in[alu_jump_pkg::FLAG_C];
	assign sum9   = {1'b0, dst_val} + {1'b0, b} + {8'h00, cin};    // [RL1]
	assign dif9   = {1'b0, dst_val} - {1'b0, b} - {8'h00, cin};    // [RL3] [RL4]
	assign neg9   = {1'b0, alu_jump_pkg::ALL_ZERO} - {1'b0, dst_val};  // [RL6]
	assign wsum   = {1'b0, word_val} + {11'h000, imm_val[5:0]};    // [RL2]
	assign wdif   = {1'b0, word_val} - {11'h000, imm_val[5:0]};    // [RL2]
	assign rel_pc = pc_val + {{10{jump_offset[11]}}, jump_offset} + alu_jump_pkg::PC_REL_STEP;
	assign far_z  = {jump_extension_byte[5:0], z_pointer};         // [RL14]

	// ------------------------------------------------------------
	// Multiplier
	// ------------------------------------------------------------
	assign mi.a        = dst_val;
	assign mi.b        = src_val;
	assign mi.a_signed = op == alu_jump_pkg::op_signed_product ||
		op == alu_jump_pkg::op_mixed_product || op == alu_jump_pkg::op_fraction_product_s ||
		op == alu_jump_pkg::op_fraction_product_mixed;
	assign mi.b_signed = op == alu_jump_pkg::op_signed_product ||
		op == alu_jump_pkg::op_fraction_product_s;
	assign mi.frac     = op == alu_jump_pkg::op_fraction_product_u ||   // [RL12]
		op == alu_jump_pkg::op_fraction_product_s || op == alu_jump_pkg::op_fraction_product_mixed;

	product_unit u_product (
		.m (mi.unit)
	);

	// ------------------------------------------------------------
	// Result and flag selection
	// ------------------------------------------------------------
	logic [7:0]  r8;
	logic [15:0] r16;
	logic [7:0]  f;
	logic [21:0] tgt;
	logic [21:0] ret;
	logic [2:0]  cyc;
	logic [5:0]  kind;  // res, word, prod, flags, pc, call

	always_comb begin
		f    = flags_in;  // [RL16]
		r8   = dst_val;
		r16  = word_val;
		tgt  = pc_val;
		ret  = pc_val + alu_jump_pkg::RET_STEP_SHORT;
		cyc  = alu_jump_pkg::CYC_SINGLE;
		kind = 6'b100100;
		case (op)
			alu_jump_pkg::op_add_regs, alu_jump_pkg::op_add_carry: begin
				r8 = sum9[7:0];  // [RL1]
				f[alu_jump_pkg::FLAG_C] = sum9[8];
				f[alu_jump_pkg::FLAG_H] = (dst_val[3] & b[3]) | (b[3] & ~r8[3]) | (~r8[3] & dst_val[3]);
				f[alu_jump_pkg::FLAG_V] = (dst_val[7] & b[7] & ~r8[7]) | (~dst_val[7] & ~b[7] & r8[7]);
			end
			alu_jump_pkg::op_sub_regs, alu_jump_pkg::op_constant_difference,
			alu_jump_pkg::op_borrow_difference, alu_jump_pkg::op_borrow_constant_difference: begin
				r8 = dif9[7:0];  // [RL3] [RL4]
				f[alu_jump_pkg::FLAG_C] = dif9[8];
				f[alu_jump_pkg::FLAG_H] = (~dst_val[3] & b[3]) | (b[3] & r8[3]) | (r8[3] & ~dst_val[3]);
				f[alu_jump_pkg::FLAG_V] = (dst_val[7] & ~b[7] & ~r8[7]) | (~dst_val[7] & b[7] & r8[7]);
			end
			alu_jump_pkg::op_twos_inversion: begin
				r8 = neg9[7:0];  // [RL6]
				f[alu_jump_pkg::FLAG_C] = r8 != alu_jump_pkg::ALL_ZERO;
				f[alu_jump_pkg::FLAG_H] = r8[3] | dst_val[3];
				f[alu_jump_pkg::FLAG_V] = r8 == alu_jump_pkg::SIGN_ONLY;
			end
			alu_jump_pkg::op_ones_inversion: begin
				r8 = alu_jump_pkg::ALL_ONES - dst_val;  // [RL6]
				f[alu_jump_pkg::FLAG_C] = 1'b1;
				f[alu_jump_pkg::FLAG_V] = 1'b0;
			end
			alu_jump_pkg::op_and_regs, alu_jump_pkg::op_mask_with_constant,
			alu_jump_pkg::op_or_regs, alu_jump_pkg::op_merge_with_constant,
			alu_jump_pkg::op_exclusive_merge, alu_jump_pkg::op_bits_set_op,
			alu_jump_pkg::op_bits_clear_op, alu_jump_pkg::op_zero_sign_probe,
			alu_jump_pkg::op_wipe_register: begin
				f[alu_jump_pkg::FLAG_V] = 1'b0;  // [RL5]
				if (op == alu_jump_pkg::op_and_regs)
					r8 = dst_val & src_val;
				else if (op == alu_jump_pkg::op_mask_with_constant)
					r8 = dst_val & imm_val;
				else if (op == alu_jump_pkg::op_or_regs)
					r8 = dst_val | src_val;
				else if (op == alu_jump_pkg::op_merge_with_constant || op == alu_jump_pkg::op_bits_set_op)
					r8 = dst_val | imm_val;  // [RL7]
				else if (op == alu_jump_pkg::op_bits_clear_op)
					r8 = dst_val & (alu_jump_pkg::ALL_ONES - imm_val);  // [RL7]
				else if (op == alu_jump_pkg::op_zero_sign_probe)
					r8 = dst_val & dst_val;  // [RL9]
				else
					r8 = dst_val ^ (op == alu_jump_pkg::op_wipe_register ? dst_val : src_val);  // [RL10]
			end
			alu_jump_pkg::op_plus_one, alu_jump_pkg::op_minus_one: begin
				// Carry is left alone so multi-byte loops can count with it intact
				r8 = (op == alu_jump_pkg::op_plus_one) ? dst_val + 8'h01 : dst_val - 8'h01;  // [RL8]
				f[alu_jump_pkg::FLAG_V] = (op == alu_jump_pkg::op_plus_one) ?
					r8 == alu_jump_pkg::SIGN_ONLY : r8 == alu_jump_pkg::SIGN_BELOW;
			end
			alu_jump_pkg::op_fill_ones: begin
				r8   = alu_jump_pkg::ALL_ONES;  // [RL10]
				kind = 6'b100000;
			end
			alu_jump_pkg::op_word_immediate_sum, alu_jump_pkg::op_word_immediate_difference: begin
				cyc  = alu_jump_pkg::CYC_WORD;  // [RL2]
				kind = 6'b010100;
				if (op == alu_jump_pkg::op_word_immediate_sum) begin
					r16 = wsum[15:0];
					f[alu_jump_pkg::FLAG_C] = wsum[16];
					f[alu_jump_pkg::FLAG_V] = ~word_val[15] & r16[15];
				end else begin
					r16 = wdif[15:0];
					f[alu_jump_pkg::FLAG_C] = wdif[16];
					f[alu_jump_pkg::FLAG_V] = word_val[15] & ~r16[15];
				end
				f[alu_jump_pkg::FLAG_Z] = r16 == 16'h0000;
				f[alu_jump_pkg::FLAG_N] = r16[15];
				f[alu_jump_pkg::FLAG_S] = r16[15] ^ f[alu_jump_pkg::FLAG_V];
			end
			alu_jump_pkg::op_unsigned_product, alu_jump_pkg::op_signed_product,
			alu_jump_pkg::op_mixed_product, alu_jump_pkg::op_fraction_product_u,
			alu_jump_pkg::op_fraction_product_s, alu_jump_pkg::op_fraction_product_mixed: begin
				cyc  = alu_jump_pkg::CYC_PRODUCT;  // [RL11] [RL12]
				kind = 6'b001100;
				r16  = mi.prod;
				f[alu_jump_pkg::FLAG_C] = mi.carry;
				f[alu_jump_pkg::FLAG_Z] = mi.prod == 16'h0000;
			end
			alu_jump_pkg::op_relative_goto, alu_jump_pkg::op_pointer_goto,
			alu_jump_pkg::op_far_pointer_goto, alu_jump_pkg::op_absolute_goto: begin
				kind = 6'b000010;  // [RL13] [RL14]
				cyc  = alu_jump_pkg::CYC_SHORT_GO;
				if (op == alu_jump_pkg::op_relative_goto)
					tgt = rel_pc;
				else if (op == alu_jump_pkg::op_pointer_goto)
					tgt = {6'h00, z_pointer};
				else if (op == alu_jump_pkg::op_far_pointer_goto)
					tgt = far_z;
				else begin
					tgt = jump_target;
					cyc = alu_jump_pkg::CYC_LONG_GO;
				end
			end
			alu_jump_pkg::op_relative_routine_entry, alu_jump_pkg::op_pointer_routine_entry,
			alu_jump_pkg::op_far_pointer_routine_entry, alu_jump_pkg::op_direct_routine_entry: begin
				kind = 6'b000011;  // [RL15]
				cyc  = alu_jump_pkg::CYC_CALL;
				if (op == alu_jump_pkg::op_relative_routine_entry)
					tgt = rel_pc;
				else if (op == alu_jump_pkg::op_pointer_routine_entry)
					tgt = {6'h00, z_pointer};
				else if (op == alu_jump_pkg::op_far_pointer_routine_entry)
					tgt = far_z;
				else begin
					tgt = jump_target;
					ret = pc_val + alu_jump_pkg::RET_STEP_LONG;  // Two-word instruction
					cyc = alu_jump_pkg::CYC_FAR_CALL;
				end
			end
			default: kind = alu_jump_pkg::KIND_RESET;
		endcase
		if (cyc == alu_jump_pkg::CYC_SINGLE && kind[2]) begin
			f[alu_jump_pkg::FLAG_Z] = r8 == alu_jump_pkg::ALL_ZERO;
			f[alu_jump_pkg::FLAG_N] = r8[7];
			// Borrow forms chain zero across bytes: stays clear once cleared
			if (op == alu_jump_pkg::op_borrow_difference ||
				op == alu_jump_pkg::op_borrow_constant_difference)
				f[alu_jump_pkg::FLAG_Z] = f[alu_jump_pkg::FLAG_Z] & flags_in[alu_jump_pkg::FLAG_Z];
		end
	end

	// ------------------------------------------------------------
	// Sequencing
	// ------------------------------------------------------------
	logic [2:0] cnt_q;
	logic [5:0] kind_q;
	logic       fire_q;
	logic       ret_q;

	assign busy = cnt_q != alu_jump_pkg::CNT_RESET;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q  <= alu_jump_pkg::CNT_RESET;
			fire_q <= 1'b0;
			ret_q  <= 1'b0;
		end else begin
			fire_q <= (accept && cyc == alu_jump_pkg::CYC_SINGLE) || cnt_q == 3'h1;
			// Return address goes out right away, well ahead of the redirect
			ret_q  <= accept & kind[0];  // [RL16]
			if (accept)
				cnt_q <= cyc - 3'h1;
			else if (busy)
				cnt_q <= cnt_q - 3'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			kind_q    <= alu_jump_pkg::KIND_RESET;
			res_data  <= alu_jump_pkg::ALL_ZERO;
			word_data <= 16'h0000;
			prod_data <= 16'h0000;
			flags_out <= alu_jump_pkg::ALL_ZERO;
			pc_data   <= 22'h000000;
			ret_data  <= 22'h000000;
		end else if (accept) begin
			kind_q    <= kind;
			res_data  <= r8;
			word_data <= r16;
			prod_data <= r16;
			flags_out <= f;
			pc_data   <= tgt;
			ret_data  <= ret;
		end
	end

	assign done     = fire_q;
	assign res_we   = fire_q & kind_q[5];
	assign word_we  = fire_q & kind_q[4];
	assign prod_we  = fire_q & kind_q[3];
	assign flags_we = fire_q & kind_q[2];
	assign pc_we    = fire_q & kind_q[1];
	assign ret_we   = ret_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_ADD_ONE_CYCLE: assert property (accept && op == alu_jump_pkg::op_add_regs |=> res_we && // [RL1]
		res_data == 8'($past(dst_val) + $past(src_val))) else $error("add result or timing wrong");
	AST_WORD_TWO: assert property (accept && op == alu_jump_pkg::op_word_immediate_sum |=> // [RL2]
		busy && !word_we ##1 word_we && flags_we) else $error("word sum not two cycles");
	AST_SUB_VALUE: assert property (accept && op == alu_jump_pkg::op_sub_regs |=> // [RL3]
		res_data == 8'($past(dst_val) - $past(src_val))) else $error("difference wrong");
	AST_BORROW: assert property (accept && op == alu_jump_pkg::op_borrow_difference |=> // [RL4]
		res_data == 8'($past(dst_val) - $past(src_val) - 8'($past(flags_in[0]))))
		else $error("borrow difference wrong");
	AST_LOGIC_FLAGS: assert property (accept && op == alu_jump_pkg::op_and_regs |=> // [RL5]
		!flags_out[alu_jump_pkg::FLAG_V] && flags_out[0] == $past(flags_in[0]))
		else $error("logic op touched carry");
	AST_ONES_INV: assert property (accept && op == alu_jump_pkg::op_ones_inversion |=> // [RL6]
		res_data == ~$past(dst_val) && flags_out[0]) else $error("ones inversion wrong");
	AST_INC_CARRY: assert property (accept && op == alu_jump_pkg::op_plus_one |=> // [RL8]
		flags_out[0] == $past(flags_in[0])) else $error("increment changed carry");
	AST_FILL: assert property (accept && op == alu_jump_pkg::op_fill_ones |=> // [RL10]
		res_we && !flags_we && res_data == alu_jump_pkg::ALL_ONES) else $error("fill wrong");
	AST_PRODUCT: assert property (accept && op == alu_jump_pkg::op_unsigned_product |=> // [RL11]
		##1 prod_we && prod_data == 16'($past(dst_val, 2) * $past(src_val, 2)))
		else $error("product wrong");
	AST_ABS_GOTO: assert property (accept && op == alu_jump_pkg::op_absolute_goto |=> // [RL13]
		!pc_we [*2] ##1 pc_we && pc_data == $past(jump_target, 3)) else $error("goto timing");
	AST_CALL_ORDER: assert property (accept && op == alu_jump_pkg::op_direct_routine_entry |=> // [RL15]
		ret_we && !pc_we ##4 pc_we) else $error("call order or timing wrong");

	COV_MUL: cover property (accept && op == alu_jump_pkg::op_fraction_product_s);
	COV_CALL: cover property (accept && op == alu_jump_pkg::op_far_pointer_routine_entry);
	COV_B2B: cover property (done && accept);
endmodule : alu_jump_unit

// ---- src/alu_jump_pkg.sv ----
package alu_jump_pkg;

	// ------------------------------------------------------------
	// Operation codes handed over by the instruction decoder
	// ------------------------------------------------------------
	typedef enum logic [5:0] {
		op_add_regs                  = 6'h00,
		op_add_carry                 = 6'h01,
		op_word_immediate_sum        = 6'h02,
		op_sub_regs                  = 6'h03,
		op_constant_difference       = 6'h04,
		op_borrow_difference         = 6'h05,
		op_borrow_constant_difference = 6'h06,
		op_word_immediate_difference = 6'h07,
		op_and_regs                  = 6'h08,
		op_mask_with_constant        = 6'h09,
		op_or_regs                   = 6'h0a,
		op_merge_with_constant       = 6'h0b,
		op_exclusive_merge           = 6'h0c,
		op_ones_inversion            = 6'h0d,
		op_twos_inversion            = 6'h0e,
		op_bits_set_op               = 6'h0f,
		op_bits_clear_op             = 6'h10,
		op_plus_one                  = 6'h11,
		op_minus_one                 = 6'h12,
		op_zero_sign_probe           = 6'h13,
		op_wipe_register             = 6'h14,
		op_fill_ones                 = 6'h15,
		op_unsigned_product          = 6'h16,
		op_signed_product            = 6'h17,
		op_mixed_product             = 6'h18,
		op_fraction_product_u        = 6'h19,
		op_fraction_product_s        = 6'h1a,
		op_fraction_product_mixed    = 6'h1b,
		op_relative_goto             = 6'h1c,
		op_pointer_goto              = 6'h1d,
		op_far_pointer_goto          = 6'h1e,
		op_absolute_goto             = 6'h1f,
		op_relative_routine_entry    = 6'h20,
		op_pointer_routine_entry     = 6'h21,
		op_far_pointer_routine_entry = 6'h22,
		op_direct_routine_entry      = 6'h23
	} op_type;

	// ------------------------------------------------------------
	// Status register bit positions
	// ------------------------------------------------------------
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;

	// ------------------------------------------------------------
	// Widths, cycle counts, reset values
	// ------------------------------------------------------------
	localparam int PC_WIDTH  = 22;
	localparam int OFS_WIDTH = 12;

	localparam logic [2:0] CYC_SINGLE   = 3'h1;
	localparam logic [2:0] CYC_WORD     = 3'h2;
	localparam logic [2:0] CYC_PRODUCT  = 3'h2;
	localparam logic [2:0] CYC_SHORT_GO = 3'h2;
	localparam logic [2:0] CYC_LONG_GO  = 3'h3;
	localparam logic [2:0] CYC_CALL     = 3'h4;
	localparam logic [2:0] CYC_FAR_CALL = 3'h5;

	localparam logic [21:0] RET_STEP_SHORT = 22'h000001;
	localparam logic [21:0] RET_STEP_LONG  = 22'h000002;
	localparam logic [21:0] PC_REL_STEP    = 22'h000001;

	localparam logic [7:0]  ALL_ONES    = 8'hff;
	localparam logic [7:0]  ALL_ZERO    = 8'h00;
	localparam logic [7:0]  SIGN_ONLY   = 8'h80;
	localparam logic [7:0]  SIGN_BELOW  = 8'h7f;
	localparam logic [15:0] WORD_SIGN   = 16'h8000;
	localparam logic [2:0]  CNT_RESET   = 3'h0;
	localparam logic [5:0]  KIND_RESET  = 6'h00;

endpackage : alu_jump_pkg

// ---- src/mult_if.sv ----
`timescale 1ns/1ps
interface mult_if;
	logic [7:0]  a;
	logic [7:0]  b;
	logic        a_signed;
	logic        b_signed;
	logic        frac;
	logic [15:0] prod;
	logic        carry;

	modport core (output a, output b, output a_signed, output b_signed, output frac,
		input prod, input carry);
	modport unit (input a, input b, input a_signed, input b_signed, input frac,
		output prod, output carry);
endinterface : mult_if

// ---- src/product_unit.sv ----
`timescale 1ns/1ps
module product_unit (
	mult_if.unit m
);
	logic signed [8:0]  ax;
	logic signed [8:0]  bx;
	logic signed [17:0] full;

	assign ax = {m.a_signed & m.a[7], m.a};
	assign bx = {m.b_signed & m.b[7], m.b};
	assign full = ax * bx;
	// Carry reflects the raw product, before the fractional shift
	assign m.carry = full[15];
	assign m.prod = m.frac ? {full[14:0], 1'b0} : full[15:0];
endmodule : product_unit

// ---- bench/alu_partner.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// Status register of the core, as the far side holds it
// ------------------------------------------------------------
module alu_partner (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       flags_we,
	input  wire logic [7:0] flags_out,
	output logic      [7:0] flags_in
);
	logic [7:0] sreg_q;

	// Write-through, so an op taken in the done cycle sees the fresh flags
	assign flags_in = (flags_we === 1'b1) ? flags_out : sreg_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			sreg_q <= 8'h00;
		else if (flags_we)
			sreg_q <= flags_out;
	end

	task automatic preset(input logic [7:0] v);
		sreg_q = v;
	endtask : preset
endmodule : alu_partner

// ---- bench/cpu_alu_and_jump_unit_bench.sv ----
`timescale 1ns/1ps
module cpu_alu_and_jump_unit_bench;
	logic                 clk = 1'b0;
	logic                 rst_n = 1'b0;
	logic                 op_valid = 1'b0;
	alu_jump_pkg::op_type op_code = alu_jump_pkg::op_add_regs;
	logic [7:0]           dst_val = 8'h00, src_val = 8'h00, imm_val = 8'h00, ext_val = 8'h00;
	logic [15:0]          word_val = 16'h0000, z_pointer = 16'h1234;
	logic [21:0]          pc_val = 22'h000100, jump_target = 22'h3abcde;
	logic [11:0]          jump_offset = 12'hf00;
	logic                 busy, done, res_we, word_we, prod_we, flags_we, pc_we, ret_we;
	logic [7:0]           res_data, flags_out, flags_in, f_q, e_res, e_flags;
	logic [15:0]          word_data, prod_data, e_word, e_prod;
	logic [21:0]          pc_data, ret_data, e_pc, e_ret;
	logic                 is_call;
	int                   e_kind, e_cyc, err_count, checks, cyc_n;

	always #50 clk = ~clk;

	alu_jump_unit u_alu_jump_unit (.clk(clk), .rst_n(rst_n), .op_valid(op_valid),
		.op_code(op_code), .dst_val(dst_val), .src_val(src_val), .imm_val(imm_val),
		.word_val(word_val), .flags_in(flags_in), .pc_val(pc_val),
		.jump_offset(jump_offset), .jump_target(jump_target), .z_pointer(z_pointer),
		.jump_extension_byte(ext_val), .busy(busy), .done(done), .res_we(res_we),
		.res_data(res_data), .word_we(word_we), .word_data(word_data), .prod_we(prod_we),
		.prod_data(prod_data), .flags_we(flags_we), .flags_out(flags_out), .pc_we(pc_we),
		.pc_data(pc_data), .ret_we(ret_we), .ret_data(ret_data));

	alu_partner u_alu_partner (.clk(clk), .rst_n(rst_n), .flags_we(flags_we),
		.flags_out(flags_out), .flags_in(flags_in));

	// ------------------------------------------------------------
	// Checking and closing
	// ------------------------------------------------------------
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic stop_test();
		$display("checks %0d, mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test

	always @(posedge clk) begin
		cyc_n++;
		if (cyc_n == 3000) begin
			err_count++;
			stop_test();
		end
	end

	// ------------------------------------------------------------
	// Reference model; flag bits are C0 Z1 N2 V3 S4 H5
	// ------------------------------------------------------------
	task automatic lg(input logic [7:0] v);
		e_res = v;
		e_flags[3] = 1'b0;
		e_flags[2] = v[7];
		e_flags[1] = (v == 8'h00);
	endtask : lg

	task automatic arith(input logic [7:0] a, input logic [7:0] b, input logic ci, sb, kz);
		logic [8:0] t;
		logic [7:0] r;
		t = sb ? {1'b0, a} - {1'b0, b} - ci : {1'b0, a} + {1'b0, b} + ci;
		r = t[7:0];
		lg(r);
		e_flags[0] = t[8];
		// Borrow forms only keep Z set if it was already set
		e_flags[1] = (r == 8'h00) & (~kz | f_q[1]);
		e_flags[5] = sb ? (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3])
			: (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
		e_flags[3] = sb ? (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7])
			: (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
	endtask : arith

	task automatic predict();
		int o;
		logic [15:0] pa, pb, pp, wr;
		o = int'(op_code);
		e_flags = f_q;
		e_kind = 0;
		e_cyc = 1;
		is_call = (o >= 32);
		e_ret = pc_val + ((o == 35) ? 22'h000002 : 22'h000001);
		if (o == 2 || o == 7) begin
			wr = (o == 7) ? word_val - {10'h000, imm_val[5:0]} : word_val + {10'h000, imm_val[5:0]};
			e_word = wr;
			e_kind = 1;
			e_cyc = 2;
			e_flags[2] = wr[15];
			e_flags[1] = (wr == 16'h0000);
			e_flags[3] = (o == 7) ? word_val[15] & ~wr[15] : ~word_val[15] & wr[15];
			e_flags[0] = (o == 7) ? wr[15] & ~word_val[15] : ~wr[15] & word_val[15];
			e_flags[4] = e_flags[2] ^ e_flags[3];
		end else if (o >= 22 && o <= 27) begin
			pa = {{8{dst_val[7] & (o inside {23, 24, 26, 27})}}, dst_val};
			pb = {{8{src_val[7] & (o == 23 || o == 26)}}, src_val};
			pp = pa * pb;
			e_flags[0] = pp[15];
			e_prod = (o >= 25) ? pp << 1 : pp;
			e_flags[1] = (e_prod == 16'h0000);
			e_kind = 2;
			e_cyc = 2;
		end else if (o >= 28) begin
			e_kind = 3;
			e_cyc = (o < 31) ? 2 : (o == 31) ? 3 : (o == 35) ? 5 : 4;
			case (o % 4)
				0: e_pc = pc_val + {{10{jump_offset[11]}}, jump_offset} + 22'h000001;
				1: e_pc = {6'h00, z_pointer};
				2: e_pc = {ext_val[5:0], z_pointer};
				default: e_pc = jump_target;
			endcase
		end else begin
			case (o)
				0, 1: arith(dst_val, src_val, o == 1 & f_q[0], 1'b0, 1'b0);
				3, 5: arith(dst_val, src_val, o == 5 & f_q[0], 1'b1, o == 5);
				4, 6: arith(dst_val, imm_val, o == 6 & f_q[0], 1'b1, o == 6);
				8: lg(dst_val & src_val);
				9: lg(dst_val & imm_val);
				10: lg(dst_val | src_val);
				11, 15: lg(dst_val | imm_val);
				12: lg(dst_val ^ src_val);
				13: begin
					lg(8'hff - dst_val);
					e_flags[0] = 1'b1;
				end
				14: arith(8'h00, dst_val, 1'b0, 1'b1, 1'b0);
				16: lg(dst_val & (8'hff - imm_val));
				17, 18: begin
					arith(dst_val, 8'h01, 1'b0, o == 18, 1'b0);
					e_flags[0] = f_q[0];
					e_flags[5] = f_q[5];
				end
				19: lg(dst_val & dst_val);
				20: lg(dst_val ^ dst_val);
				default: e_res = 8'hff;
			endcase
		end
	endtask : predict

	// ------------------------------------------------------------
	// Decoder side: one op, left high into the done cycle for back to back
	// ------------------------------------------------------------
	task automatic run_op(input int i);
		int n;
		op_code = alu_jump_pkg::op_type'(i);
		if (op_valid !== 1'b1)
			op_valid = 1'b1;
		predict();
		n = 0;
		do begin
			@(negedge clk);
			n++;
			if (n == 1)
				chk(ret_we, is_call);
			if (n == 1 && is_call)
				chk(ret_data, e_ret);
			if (done !== 1'b1)
				op_valid = 1'b0;
			if (done !== 1'b1)
				chk(busy, 1'b1);
		end while (done !== 1'b1 && n < 8);
		chk(n, e_cyc);
		chk(busy, 1'b0);
		chk((flags_we === 1'b1) ? flags_out : f_q, e_flags);
		case (e_kind)
			0: chk({res_we, res_data}, {1'b1, e_res});
			1: chk({word_we, word_data}, {1'b1, e_word});
			2: chk({prod_we, prod_data}, {1'b1, e_prod});
			default: chk({pc_we, pc_data}, {1'b1, e_pc});
		endcase
		f_q = e_flags;
	endtask : run_op

	task automatic pass(input logic [7:0] dv, sv, kv, fv, input logic [15:0] wv, input int lo, hi);
		@(negedge clk);
		dst_val = dv;
		src_val = sv;
		imm_val = kv;
		word_val = wv;
		f_q = fv;
		u_alu_partner.preset(fv);
		for (int i = lo; i <= hi; i++)
			run_op(i);
		op_valid = 1'b0;
	endtask : pass

	initial begin
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		pass(8'h8f, 8'h71, 8'h3c, 8'h01, 16'h7ffe, 0, 21);
		pass(8'h00, 8'hff, 8'h01, 8'h02, 16'h0000, 0, 21);
		$display("test byte and word ops done");
		pass(8'h80, 8'hff, 8'h00, 8'h00, 16'h0000, 22, 27);
		pass(8'hc0, 8'h40, 8'h00, 8'h23, 16'h8000, 22, 27);
		$display("test products done");
		pass(8'h00, 8'h00, 8'h00, 8'h3f, 16'h0000, 28, 35);
		ext_val = 8'hc5;
		jump_offset = 12'h07f;
		pc_val = 22'h3ffff0;
		pass(8'h00, 8'h00, 8'h00, 8'h00, 16'h0000, 28, 35);
		$display("test gotos and calls done");
		stop_test();
	end
endmodule : cpu_alu_and_jump_unit_bench
